// *** design/irap_consts.vh ***
// Constants shared by the two-wire register access port.
`ifndef IRAP_CONSTS_VH
`define IRAP_CONSTS_VH

// ----------------------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------------------
// Upper four bits of the 7-bit slave address; the three straps fill the rest.
`define IRAP_SLV_ADDR_HI 4'hD
`define IRAP_RW_BIT 0

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define IRAP_OP_READ 3'h4
`define IRAP_OP_WRITE 3'h3

// ----------------------------------------------------------------------------
// Field positions in the 32-bit command word, command byte 0 in bits 31:24
// ----------------------------------------------------------------------------
`define IRAP_F_OP_MSB 26
`define IRAP_F_OP_LSB 24
`define IRAP_F_PORT_HI_MSB 19
`define IRAP_F_PORT_HI_LSB 16
`define IRAP_F_PORT_LO 15
`define IRAP_F_BE_MSB 13
`define IRAP_F_BE_LSB 10
`define IRAP_F_ADDR_HI_MSB 9
`define IRAP_F_ADDR_HI_LSB 8
`define IRAP_F_ADDR_LO_MSB 7
`define IRAP_F_ADDR_LO_LSB 0

// ----------------------------------------------------------------------------
// Byte and bit counts
// ----------------------------------------------------------------------------
`define IRAP_BIT_LAST 4'h8
`define IRAP_BIT_ACK 4'h9
`define IRAP_IDX_CMD_LAST 4'h3
`define IRAP_IDX_DATA_LAST 4'h7
`define IRAP_IDX_SAT 4'h8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IRAP_BUF_RST 32'h00000000

`endif

// *** design/irap_line_mon.v ***
// Bus line monitor: clock edges and start/stop conditions of the two-wire bus.
`timescale 1ns/1ps

module irap_line_mon (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Bus lines, already synchronous to clk_i
	input wire scl_i,
	input wire sda_i,
	// Line events, one cycle each
	output wire scl_rise_o,
	output wire scl_fall_o,
	output wire start_o,
	output wire stop_o
);

reg scl_q;
reg sda_q;

// Idle bus is high on both lines, so the history starts there to avoid a false edge.
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
	end else begin
		scl_q <= scl_i;
		sda_q <= sda_i;
	end
end

assign scl_rise_o = scl_i & ~scl_q;
assign scl_fall_o = ~scl_i & scl_q;
// Data moving while the clock stays high frames a transfer.
assign start_o = scl_i & scl_q & sda_q & ~sda_i;
assign stop_o = scl_i & scl_q & ~sda_q & sda_i;

endmodule // irap_line_mon

// *** design/irap_port.v ***
// Two-wire slave port giving an outside master read and write access to port registers.
`timescale 1ns/1ps
`include "irap_consts.vh"

module irap_port (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Two-wire bus, open drain data
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	// Slave address straps
	input wire [2:0] strap_i,
	// Register request to the port register files
	output reg reg_rd_o,
	output reg reg_wr_o,
	output reg [4:0] reg_port_o,
	output reg [11:0] reg_addr_o,
	output reg [3:0] reg_be_o,
	output reg [31:0] reg_wdata_o,
	// Register read answer
	input wire reg_rvalid_i,
	input wire [31:0] reg_rdata_i,
	// Status
	output reg fetch_busy_o,
	output reg busy_o
);

// ----------------------------------------------------------------------------
// States
// ----------------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_WRX = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_MACK = 3'h4;

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
function [7:0] pick_byte;
	input [31:0] word;
	input [1:0] idx;
	begin
		case (idx)
			2'h0: pick_byte = word[31:24];
			2'h1: pick_byte = word[23:16];
			2'h2: pick_byte = word[15:8];
			default: pick_byte = word[7:0];
		endcase
	end
endfunction

reg [2:0] state;
reg [3:0] bit_cnt;
reg [3:0] byte_idx;
reg [7:0] rx_sr;
reg [7:0] tx_sr;
reg [1:0] tx_idx;
reg [31:0] cmd_sr;
reg [23:0] wdata_sr;
reg [2:0] op_code;
reg [31:0] hold_buf;

wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire [31:0] next_cmd;
wire [7:0] first_byte;
wire [7:0] next_byte;
wire addr_hit;

irap_line_mon u_line_mon (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.scl_rise_o(scl_rise),
	.scl_fall_o(scl_fall),
	.start_o(start_det),
	.stop_o(stop_det)
);

assign next_cmd = {cmd_sr[23:0], rx_sr};
assign addr_hit = (rx_sr[7:1] == {`IRAP_SLV_ADDR_HI, strap_i});
assign first_byte = pick_byte(hold_buf, 2'h0);
assign next_byte = pick_byte(hold_buf, tx_idx);

// ----------------------------------------------------------------------------
// Protocol engine
// ----------------------------------------------------------------------------
// The device only changes the data line after a clock fall, so its own drive
// can never look like a start or stop to the line monitor.
always @(posedge clk_i or posedge rst_i) begin
	if (rst_i) begin
		state <= ST_IDLE;
		bit_cnt <= 4'h0;
		byte_idx <= 4'h0;
		rx_sr <= 8'h00;
		tx_sr <= 8'h00;
		tx_idx <= 2'h0;
		cmd_sr <= 32'h00000000;
		wdata_sr <= 24'h000000;
		op_code <= 3'h0;
		hold_buf <= `IRAP_BUF_RST;
		sda_o <= 1'b0;
		sda_oe_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_wr_o <= 1'b0;
		reg_port_o <= 5'h00;
		reg_addr_o <= 12'h000;
		reg_be_o <= 4'h0;
		reg_wdata_o <= 32'h00000000;
		fetch_busy_o <= 1'b0;
		busy_o <= 1'b0;
	end else begin
		reg_rd_o <= 1'b0;
		reg_wr_o <= 1'b0;
		sda_o <= 1'b0;
		busy_o <= (state != ST_IDLE);
		if (reg_rvalid_i) begin
			hold_buf <= reg_rdata_i;
			fetch_busy_o <= 1'b0;
		end
		if (stop_det) begin
			state <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else if (start_det) begin
			// A repeated start keeps the command, so both read forms work.
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe_o <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_WRX: begin
					if (scl_rise && bit_cnt < `IRAP_BIT_LAST) begin
						rx_sr <= {rx_sr[6:0], sda_i};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `IRAP_BIT_LAST) begin
						bit_cnt <= `IRAP_BIT_ACK;
						if (state == ST_ADDR) begin
							if (addr_hit) begin
								sda_oe_o <= 1'b1;
								byte_idx <= 4'h0;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							sda_oe_o <= 1'b1;
							if (byte_idx != `IRAP_IDX_SAT) begin
								byte_idx <= byte_idx + 4'h1;
							end
							if (byte_idx < `IRAP_IDX_CMD_LAST) begin
								cmd_sr <= next_cmd;
							end else if (byte_idx == `IRAP_IDX_CMD_LAST) begin
								cmd_sr <= next_cmd;
								op_code <= next_cmd[`IRAP_F_OP_MSB:`IRAP_F_OP_LSB];
								reg_port_o <= {next_cmd[`IRAP_F_PORT_HI_MSB:`IRAP_F_PORT_HI_LSB],
									next_cmd[`IRAP_F_PORT_LO]};
								reg_be_o <= next_cmd[`IRAP_F_BE_MSB:`IRAP_F_BE_LSB];
								reg_addr_o <= {next_cmd[`IRAP_F_ADDR_HI_MSB:`IRAP_F_ADDR_HI_LSB],
									next_cmd[`IRAP_F_ADDR_LO_MSB:`IRAP_F_ADDR_LO_LSB],
									2'b00};
								// Reserved bits are simply never decoded.
								if (next_cmd[`IRAP_F_OP_MSB:`IRAP_F_OP_LSB] == `IRAP_OP_READ) begin
									reg_rd_o <= 1'b1;
									fetch_busy_o <= 1'b1;
								end
							end else if (byte_idx < `IRAP_IDX_DATA_LAST) begin
								wdata_sr <= {wdata_sr[15:0], rx_sr};
							end else if (byte_idx == `IRAP_IDX_DATA_LAST) begin
								if (op_code == `IRAP_OP_WRITE) begin
									reg_wdata_o <= {wdata_sr, rx_sr};
									reg_wr_o <= 1'b1;
								end
							end
						end
					end else if (scl_fall && bit_cnt == `IRAP_BIT_ACK) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR && rx_sr[`IRAP_RW_BIT]) begin
							// Read transaction: drive the first bit right away.
							state <= ST_TX;
							tx_sr <= first_byte;
							tx_idx <= 2'h1;
							sda_oe_o <= ~first_byte[7];
						end else begin
							state <= ST_WRX;
							sda_oe_o <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == `IRAP_BIT_LAST) begin
							sda_oe_o <= 1'b0;
							state <= ST_MACK;
						end else begin
							tx_sr <= {tx_sr[6:0], 1'b0};
							sda_oe_o <= ~tx_sr[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_i) begin
						// Master declined more data; wait for stop or start.
						state <= ST_IDLE;
					end else if (scl_fall) begin
						state <= ST_TX;
						bit_cnt <= 4'h0;
						tx_sr <= next_byte;
						tx_idx <= tx_idx + 2'h1;
						sda_oe_o <= ~next_byte[7];
					end
				end
				default: begin
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end
end

endmodule // irap_port

// *** testbench/irap_port_monitor.sv ***
// Concurrent checks on the ports of the two-wire register access port.
`timescale 1ns/1ps

module irap_port_mon (
	input wire clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_oe_o,
	input wire reg_rd_o,
	input wire reg_wr_o,
	input wire [11:0] reg_addr_o,
	input wire reg_rvalid_i,
	input wire fetch_busy_o,
	input wire busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	rd_pulse_a: assert property (reg_rd_o |=> !reg_rd_o) else $error("fetch pulse too long");
	wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o) else $error("write pulse too long");
	fetch_set_a: assert property ($rose(fetch_busy_o) |-> reg_rd_o) else $error("busy no fetch");
	fetch_clr_a: assert property (fetch_busy_o && reg_rvalid_i && !reg_rd_o |=> !fetch_busy_o)
		else $error("fetch busy stuck");
	addr_align_a: assert property (reg_addr_o[1:0] == 2'h0) else $error("address not aligned");
	excl_req_a: assert property (!(reg_rd_o && reg_wr_o)) else $error("read and write at once");
	sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
	busy_req_a: assert property (reg_wr_o |-> busy_o) else $error("write while idle");
endmodule // irap_port_mon

bind irap_port irap_port_mon i_mon (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
	.sda_oe_o(sda_oe_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
	.reg_rvalid_i(reg_rvalid_i), .fetch_busy_o(fetch_busy_o), .busy_o(busy_o));

// *** testbench/irap_port_tb.sv ***
// Self-checking testbench for the two-wire register access port.
`timescale 1ns/1ps

module irap_port_tb;
	logic clk_i = 1'b0, rst_i = 1'b1, scl = 1'b1, sda_m = 1'b1, r;
	logic sda_o, sda_oe_o, rd, wr, rvalid, fbusy, busy;
	logic [4:0] port;
	logic [11:0] addr;
	logic [3:0] be;
	logic [31:0] wdata, rdata;
	logic [7:0] d;
	logic [39:0] q = 40'h00BB00DD00;
	wire sda_i = sda_m & ~(sda_oe_o & ~sda_o);
	int n_errors = 0, checks = 0, n_wr = 0, n_rd = 0;

	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_wr <= n_wr + wr;
		n_rd <= n_rd + rd;
	end

	irap_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .strap_i(3'h0), .reg_rd_o(rd), .reg_wr_o(wr), .reg_port_o(port),
		.reg_addr_o(addr), .reg_be_o(be), .reg_wdata_o(wdata), .reg_rvalid_i(rvalid),
		.reg_rdata_i(rdata), .fetch_busy_o(fbusy), .busy_o(busy));
	irap_regs_model i_regs (.clk_i(clk_i), .rd_i(rd), .wr_i(wr), .port_i(port), .addr_i(addr),
		.be_i(be), .wdata_i(wdata), .rvalid_o(rvalid), .rdata_o(rdata));

	task chk(string s, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task w(int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Each line step lasts two clocks, so every bus edge is well apart from the sampling edge.
	task ln(logic c, logic s);
		scl = c;
		sda_m = s;
		w(2);
	endtask
	task bt(logic b);
		ln(1'b0, b);
		ln(1'b1, b);
		r = sda_i;
		ln(1'b1, b);
		ln(1'b0, b);
	endtask
	task sta;
		ln(1'b0, 1'b1);
		ln(1'b1, 1'b1);
		ln(1'b1, 1'b0);
		ln(1'b0, 1'b0);
	endtask
	task sto;
		ln(1'b0, 1'b0);
		ln(1'b1, 1'b0);
		ln(1'b1, 1'b1);
	endtask
	task wb(logic [7:0] v, logic ack);
		for (int i = 7; i >= 0; i--) bt(v[i]);
		bt(1'b1);
		chk("ack", ack, !r);
	endtask
	task rb(logic [7:0] e, logic last);
		for (int i = 7; i >= 0; i--) begin
			bt(1'b1);
			d[i] = r;
		end
		bt(last);
		chk("rdata", e, d);
	endtask
	task w4(logic [31:0] v);
		for (int i = 3; i >= 0; i--) wb(v[8*i +: 8], 1'b1);
	endtask
	task cmd(logic [31:0] c);
		sta;
		wb(8'hD0, 1'b1);
		w4(c);
	endtask
	task summarize;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#500000;
		n_errors++;
		summarize;
	end

	initial begin
		w(8);
		rst_i = 1'b0;
		w(4);
		cmd(32'hFB003C3E);
		w4(32'h12345678);
		sto;
		chk("wr count", 32'h1, n_wr);
		chk("wdata", 32'h12345678, wdata);
		chk("request", {5'h00, 12'h0F8, 4'hF}, {port, addr, be});
		chk("busy", 32'h0, busy);
		chk("sda_o", 32'h0, sda_o);
		$display("full write done");
		cmd(32'h03011512);
		w4(32'hAABBCCDD);
		sto;
		chk("request", {5'h02, 12'h448, 4'h5}, {port, addr, be});
		cmd(32'h04011512);
		chk("rd count", 32'h1, n_rd);
		chk("fetch busy", 32'h0, fbusy);
		sta;
		wb(8'hD1, 1'b1);
		for (int i = 0; i < 5; i++) rb(q[39-8*i -: 8], i == 4);
		sto;
		$display("read with wrap done");
		sta;
		wb(8'hD2, 1'b0);
		sto;
		cmd(32'h05011512);
		w4(32'h11111111);
		sto;
		chk("req counts", 32'h21, {n_wr[3:0], n_rd[3:0]});
		$display("refusals done");
		summarize;
	end
endmodule // irap_port_tb

// *** testbench/irap_regs_model.sv ***
// Port register file model answering fetches and byte-enabled writes.
`timescale 1ns/1ps

module irap_regs_model (
	input wire clk_i,
	input wire rd_i,
	input wire wr_i,
	input wire [4:0] port_i,
	input wire [11:0] addr_i,
	input wire [3:0] be_i,
	input wire [31:0] wdata_i,
	output logic rvalid_o = 1'b0,
	output logic [31:0] rdata_o = 32'hA5A5A5A5
);
	logic [31:0] mem [logic [16:0]];
	logic [31:0] cur;
	// Fetches answer slowly, and the data lines are scrambled outside the answer cycle.
	always @(posedge clk_i) begin
		cur = mem.exists({port_i, addr_i}) ? mem[{port_i, addr_i}] : 32'h00000000;
		if (wr_i) begin
			for (int i = 0; i < 4; i++)
				if (be_i[i]) cur[8*i +: 8] = wdata_i[8*i +: 8];
			mem[{port_i, addr_i}] = cur;
		end
		if (rd_i) begin
			repeat (5) @(posedge clk_i);
			rdata_o <= cur;
			rvalid_o <= 1'b1;
			@(posedge clk_i);
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
		end
	end
endmodule // irap_regs_model
